// ---- common/ctpf_pkg.sv ----
// Constants for the camera trigger, PWM and frame information registers
package ctpf_pkg;
    // Bus geometry
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 32;
    localparam int          GPIO_N          = 4;
    // Register byte addresses
    localparam logic [15:0] OFS_TRIG_CTRL   = 16'h0830;
    localparam logic [15:0] OFS_PIN0_CTRL   = 16'h1110;
    localparam logic [15:0] OFS_PIN0_PWM    = 16'h1114;
    localparam logic [15:0] OFS_PIN1_CTRL   = 16'h1120;
    localparam logic [15:0] OFS_PIN1_PWM    = 16'h1124;
    localparam logic [15:0] OFS_FRAME_INFO  = 16'h12f8;
    // Shared field positions
    localparam int          B_PRESENCE      = 0;
    localparam int          B_ABS_CTRL      = 1;
    localparam int          B_ON_OFF        = 6;
    localparam int          B_TRIG_POL      = 7;
    localparam int          B_TRIG_SRC_LO   = 8;
    localparam int          B_TRIG_RAW      = 11;
    localparam int          B_MODE_LO       = 12;
    localparam int          B_PARAM_LO      = 20;
    localparam int          B_INFO_LO       = 6;
    localparam int          B_ABS_SELECT    = 16;
    localparam int          B_PWM_LOW_LO    = 0;
    localparam int          B_PWM_HIGH_LO   = 16;
    localparam int          B_PWM_POL       = 31;
    // Pin mode encodings
    localparam logic [3:0]  PIN_MODE_INPUT  = 4'h0;
    localparam logic [3:0]  PIN_MODE_PWM    = 4'h4;
    // Reset values
    localparam logic [31:0] RST_PWM_TIMING  = 32'h0000_0000;
    localparam logic [2:0]  RST_TRIG_SRC    = 3'h0;
    localparam logic [3:0]  RST_TRIG_MODE   = 4'h0;
    localparam logic [11:0] RST_TRIG_PARAM  = 12'h000;
    // Timebase: system clock and PWM tick rate
    localparam int          CLK_HZ          = 20000000;
    localparam int          TB_HZ           = 1024000;
    localparam int          TB_MOD          = CLK_HZ / 1000;
    localparam int          TB_STEP         = TB_HZ / 1000;
    localparam int          TB_GAP_MIN      = CLK_HZ / TB_HZ;
    localparam int          TB_GAP_MAX      = (CLK_HZ + TB_HZ - 1) / TB_HZ;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage : ctpf_pkg

// ---- logic/ctpf_pwm.sv ----
// PWM generator for one GPIO pin, counted in timebase ticks
`timescale 1ns/100ps
`default_nettype none
module ctpf_pwm
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Control
    input  wire logic        en,
    input  wire logic        tick,
    input  wire logic        pol,
    input  wire logic [15:0] low_len,
    input  wire logic [15:0] high_len,
    // Output
    output var  logic        pwm_out
);
    logic        phase_r;
    logic [15:0] cnt_r;
    logic [15:0] len;
    logic        last;

    always_comb
    begin
        len  = phase_r ? high_len : low_len;
        last = (cnt_r + 16'h0001 >= len) || (len == 16'h0000);
    end

    // Phase length counter, low phase first
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_r <= 1'b0;
            cnt_r   <= 16'h0000;
        end
        else if (!en)
        begin
            phase_r <= 1'b0;
            cnt_r   <= 16'h0000;
        end
        else if (tick)
        begin
            if (last) // RL2 RL3
            begin
                phase_r <= ~phase_r;
                cnt_r   <= 16'h0000;
            end
            else
                cnt_r <= cnt_r + 16'h0001;
        end
    end

    // Output level, inverted when polarity is high
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            pwm_out <= 1'b0;
        else
            pwm_out <= en ? (phase_r ^ pol) : pol; // RL5
    end

    AST_PWM_PHASE_END: assert property (@(posedge clk_sys) disable iff (!rstn)
        (en && tick && !last) |=> $stable(phase_r)) // RL2
        else $error("PWM phase ended before its period");
    AST_PWM_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!en ##1 !en) |-> (pwm_out == $past(pol))) // RL5
        else $error("Idle PWM output does not follow polarity");
endmodule // ctpf_pwm
`default_nettype wire

// ---- logic/ctpf_regs.sv ----
// AXI4-Lite register bank for trigger setup, PWM timing and frame info
//
// Summary of operation
// RL1: PWM period fields count ticks of a 1.024 MHz timebase.
// RL2: Low phase length comes from bits 0 to 15 of pin timing.
// RL3: High phase length comes from bits 16 to 31 of pin timing.
// RL4: Pin mode 4 selects PWM output using the timing fields.
// RL5: One polarity bit sets PWM output sense, 0 low, 1 high.
// RL6: Presence bit 0 reads 1 where the feature exists.
// RL7: Trigger bit 1 selects value-field or absolute-value control.
// RL8: With absolute control selected, the value field ignores writes.
// RL9: Bit 6 reads feature status and writes switch trigger on or off.
// RL10: While bit 6 is 0, other trigger fields are read-only.
// RL11: Bit 7 sets external trigger active level, 0 low, 1 high.
// RL12: Bits 8 to 10 select the GPIO pin feeding the trigger.
// RL13: Bit 11 shows the raw level of the selected pin.
// RL14: Bits 12 to 15 hold trigger mode, limited to advertised modes.
// RL15: Bits 20 to 31 hold the optional 12-bit trigger parameter.
// RL16: Frame info bits 6 to 15 report available embedded items.
// RL17: Bit 16 picks relative or absolute embedding; read-only for now.
// RL18: Reserved bits read zero and ignore writes.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ctpf_regs
#(
    parameter logic [15:0] TRIG_MODE_AVAIL = 16'h0001,
    parameter logic [9:0]  INFO_AVAIL      = 10'h3ff,
    parameter logic        ABS_SELECT      = 1'b0
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output var  logic [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    // AXI4-Lite read data
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    // GPIO pins
    input  wire logic [3:0]  gpio_level,
    output var  logic [1:0]  pwm_out,
    // Trigger outputs
    output var  logic        trig_pulse,
    output var  logic        trig_enabled,
    output var  logic [3:0]  trig_mode,
    output var  logic [11:0] trig_param
);
    // Write channel state
    logic        aw_full_r;
    logic [15:0] aw_addr_r;
    logic        w_full_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        do_wr;
    logic [31:0] wmask;
    // Registers
    logic        abs_ctrl_r;
    logic        trig_on_r;
    logic        trig_pol_r;
    logic [2:0]  trig_src_r;
    logic        trig_raw_r;
    logic        trig_act_r;
    logic [31:0] pwm_timing_r [2];
    logic [3:0]  pin_mode_r [2];
    logic        pin_pol_r [2];
    // Timebase
    logic [14:0] tb_acc_r;
    logic        tb_tick_r;
    // Read path
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [31:0] trig_word;
    logic [31:0] tw;
    logic        sel_level;
    logic        act_now;

    // Write address and data are held until both are present
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_full_r     <= 1'b0;
            aw_addr_r     <= 16'h0000;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            aw_full_r     <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            w_full_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            w_full_r     <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_comb
    begin
        do_wr = aw_full_r && w_full_r && !s_axi_bvalid;
        wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                 {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
        tw    = (trig_word & ~wmask) | (w_data_r & wmask);
    end

    // Write response, error on unmapped address
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ctpf_pkg::RESP_OKAY;
        end
        else if (do_wr)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_r == ctpf_pkg::OFS_TRIG_CTRL
                          || aw_addr_r == ctpf_pkg::OFS_PIN0_CTRL
                          || aw_addr_r == ctpf_pkg::OFS_PIN0_PWM
                          || aw_addr_r == ctpf_pkg::OFS_PIN1_CTRL
                          || aw_addr_r == ctpf_pkg::OFS_PIN1_PWM
                          || aw_addr_r == ctpf_pkg::OFS_FRAME_INFO)
                          ? ctpf_pkg::RESP_OKAY : ctpf_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Trigger control register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            trig_enabled <= 1'b0;
            trig_on_r    <= 1'b0;
            abs_ctrl_r   <= 1'b0;
            trig_pol_r   <= 1'b0;
            trig_src_r   <= ctpf_pkg::RST_TRIG_SRC;
            trig_mode    <= ctpf_pkg::RST_TRIG_MODE;
            trig_param   <= ctpf_pkg::RST_TRIG_PARAM;
        end
        else if (do_wr && aw_addr_r == ctpf_pkg::OFS_TRIG_CTRL)
        begin
            trig_on_r    <= tw[ctpf_pkg::B_ON_OFF]; // RL9
            trig_enabled <= tw[ctpf_pkg::B_ON_OFF]; // RL9
            if (trig_on_r) // RL10
            begin
                abs_ctrl_r <= tw[ctpf_pkg::B_ABS_CTRL]; // RL7
                trig_pol_r <= tw[ctpf_pkg::B_TRIG_POL]; // RL11
                if (tw[ctpf_pkg::B_TRIG_SRC_LO +: 3] < 3'(ctpf_pkg::GPIO_N))
                    trig_src_r <= tw[ctpf_pkg::B_TRIG_SRC_LO +: 3]; // RL12
                if (TRIG_MODE_AVAIL[tw[ctpf_pkg::B_MODE_LO +: 4]])
                    trig_mode <= tw[ctpf_pkg::B_MODE_LO +: 4]; // RL14
                if (!abs_ctrl_r) // RL8
                    trig_param <= tw[ctpf_pkg::B_PARAM_LO +: 12]; // RL15
            end
        end
    end

    // Pin control and PWM timing registers
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                pwm_timing_r[i] <= ctpf_pkg::RST_PWM_TIMING;
                pin_mode_r[i]   <= ctpf_pkg::PIN_MODE_INPUT;
                pin_pol_r[i]    <= 1'b0;
            end
        end
        else if (do_wr)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (aw_addr_r == (i == 0 ? ctpf_pkg::OFS_PIN0_PWM
                                         : ctpf_pkg::OFS_PIN1_PWM))
                    pwm_timing_r[i] <= (pwm_timing_r[i] & ~wmask)
                                     | (w_data_r & wmask); // RL2 RL3
                if (aw_addr_r == (i == 0 ? ctpf_pkg::OFS_PIN0_CTRL
                                         : ctpf_pkg::OFS_PIN1_CTRL))
                begin
                    if (w_strb_r[1])
                        pin_mode_r[i] <= w_data_r[ctpf_pkg::B_MODE_LO +: 4];
                    if (w_strb_r[3])
                        pin_pol_r[i] <= w_data_r[ctpf_pkg::B_PWM_POL]; // RL5
                end
            end
        end
    end

    // Timebase of 1024 ticks per 20000 system cycles
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            tb_acc_r  <= 15'h0000;
            tb_tick_r <= 1'b0;
        end
        else if (tb_acc_r + 15'(ctpf_pkg::TB_STEP) >= 15'(ctpf_pkg::TB_MOD))
        begin
            tb_acc_r  <= tb_acc_r + 15'(ctpf_pkg::TB_STEP)
                       - 15'(ctpf_pkg::TB_MOD); // RL1
            tb_tick_r <= 1'b1;
        end
        else
        begin
            tb_acc_r  <= tb_acc_r + 15'(ctpf_pkg::TB_STEP);
            tb_tick_r <= 1'b0;
        end
    end

    // One PWM generator for each of pins 0 and 1
    for (genvar g = 0; g < 2; g++)
    begin : g_pwm
        ctpf_pwm u_pwm
        (
            .clk_sys  (clk_sys),
            .rstn     (rstn),
            .en       (pin_mode_r[g] == ctpf_pkg::PIN_MODE_PWM), // RL4
            .tick     (tb_tick_r),
            .pol      (pin_pol_r[g]),
            .low_len  (pwm_timing_r[g][ctpf_pkg::B_PWM_LOW_LO +: 16]),
            .high_len (pwm_timing_r[g][ctpf_pkg::B_PWM_HIGH_LO +: 16]),
            .pwm_out  (pwm_out[g])
        );
    end

    // External trigger: pin select, raw level, active edge
    always_comb
    begin
        sel_level = (trig_src_r < 3'(ctpf_pkg::GPIO_N))
                  ? gpio_level[trig_src_r[1:0]] : 1'b0; // RL12
        act_now   = trig_raw_r ~^ trig_pol_r; // RL11
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            trig_raw_r <= 1'b0;
            trig_act_r <= 1'b0;
            trig_pulse <= 1'b0;
        end
        else
        begin
            trig_raw_r <= sel_level; // RL13
            trig_act_r <= act_now;
            trig_pulse <= trig_on_r && act_now && !trig_act_r; // RL11
        end
    end

    // Read data assembly, reserved bits zero
    always_comb
    begin
        trig_word = 32'h0000_0000; // RL18
        trig_word[ctpf_pkg::B_PRESENCE]         = 1'b1; // RL6
        trig_word[ctpf_pkg::B_ABS_CTRL]         = abs_ctrl_r;
        trig_word[ctpf_pkg::B_ON_OFF]           = trig_on_r; // RL9
        trig_word[ctpf_pkg::B_TRIG_POL]         = trig_pol_r;
        trig_word[ctpf_pkg::B_TRIG_SRC_LO +: 3] = trig_src_r;
        trig_word[ctpf_pkg::B_TRIG_RAW]         = trig_raw_r; // RL13
        trig_word[ctpf_pkg::B_MODE_LO +: 4]     = trig_mode;
        trig_word[ctpf_pkg::B_PARAM_LO +: 12]   = trig_param;
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            ctpf_pkg::OFS_TRIG_CTRL:  rd_word = trig_word;
            ctpf_pkg::OFS_PIN0_PWM:   rd_word = pwm_timing_r[0];
            ctpf_pkg::OFS_PIN1_PWM:   rd_word = pwm_timing_r[1];
            ctpf_pkg::OFS_PIN0_CTRL:  rd_word = {pin_pol_r[0], 15'h0000,
                pin_mode_r[0], 11'h000, 1'b1}; // RL6
            ctpf_pkg::OFS_PIN1_CTRL:  rd_word = {pin_pol_r[1], 15'h0000,
                pin_mode_r[1], 11'h000, 1'b1}; // RL6
            ctpf_pkg::OFS_FRAME_INFO:
            begin
                rd_word[ctpf_pkg::B_PRESENCE]      = 1'b1;
                rd_word[ctpf_pkg::B_INFO_LO +: 10] = INFO_AVAIL; // RL16
                rd_word[ctpf_pkg::B_ABS_SELECT]    = ABS_SELECT; // RL17
            end
            default:                  rd_hit  = 1'b0;
        endcase
    end

    // Read channel, one outstanding read
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= ctpf_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? ctpf_pkg::RESP_OKAY
                                    : ctpf_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checking helpers
    logic [4:0]  gap_r;
    logic [15:0] rd_addr_r;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            gap_r     <= 5'h00;
            rd_addr_r <= 16'h0000;
        end
        else
        begin
            gap_r <= tb_tick_r ? 5'h01 : gap_r + 5'h01;
            if (s_axi_arvalid && s_axi_arready)
                rd_addr_r <= s_axi_araddr;
        end
    end

    AST_TB_GAP: assert property (@(posedge clk_sys) disable iff (!rstn)
        (tb_tick_r && $past(tb_tick_r, 40) == 1'b0 && gap_r != 5'h00
         && $past(gap_r) >= 5'h02) |-> (gap_r >= 5'd19 && gap_r <= 5'd20)) // RL1
        else $error("Timebase tick spacing wrong");
    AST_PRESENCE: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_axi_rvalid && rd_addr_r == ctpf_pkg::OFS_TRIG_CTRL)
        |-> s_axi_rdata[0]) // RL6
        else $error("Presence bit not set");
    AST_ABS_LOCK: assert property (@(posedge clk_sys) disable iff (!rstn)
        (do_wr && abs_ctrl_r) |=> $stable(trig_param)) // RL8
        else $error("Value field written under absolute control");
    AST_OFF_LOCK: assert property (@(posedge clk_sys) disable iff (!rstn)
        (do_wr && !trig_on_r) |=> ($stable(trig_mode) && $stable(trig_src_r)
                                  && $stable(trig_pol_r))) // RL10
        else $error("Trigger field changed while off");
    AST_ON_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
        (do_wr && aw_addr_r == ctpf_pkg::OFS_TRIG_CTRL && w_strb_r[0])
        |=> (trig_on_r == $past(w_data_r[ctpf_pkg::B_ON_OFF]))) // RL9
        else $error("On bit did not take written value");
    AST_TRIG_EDGE: assert property (@(posedge clk_sys) disable iff (!rstn)
        trig_pulse |-> ($past(trig_raw_r) == $past(trig_pol_r)
                        && $past(trig_on_r))) // RL11
        else $error("Trigger pulse without active level");
    AST_RAW_LEVEL: assert property (@(posedge clk_sys) disable iff (!rstn)
        (trig_src_r == 3'h0 ##1 trig_src_r == 3'h0)
        |-> trig_raw_r == $past(gpio_level[0])) // RL13
        else $error("Raw level does not follow selected pin");
    AST_MODE_LIMIT: assert property (@(posedge clk_sys) disable iff (!rstn)
        $changed(trig_mode) |-> TRIG_MODE_AVAIL[trig_mode]) // RL14
        else $error("Unadvertised trigger mode accepted");
    AST_FRAME_RO: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_axi_rvalid && rd_addr_r == ctpf_pkg::OFS_FRAME_INFO)
        |-> (s_axi_rdata[16] == ABS_SELECT && s_axi_rdata[31:17] == 15'h0)) // RL17
        else $error("Frame info select bit wrong");
    AST_RSV_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_axi_rvalid && rd_addr_r == ctpf_pkg::OFS_TRIG_CTRL)
        |-> (s_axi_rdata[5:2] == 4'h0 && s_axi_rdata[19:16] == 4'h0)) // RL18
        else $error("Reserved trigger bits not zero");

    COV_WRITE: cover property (@(posedge clk_sys) do_wr);
    COV_TRIG: cover property (@(posedge clk_sys) trig_pulse);
    COV_PWM: cover property (@(posedge clk_sys) $rose(pwm_out[0]));
endmodule // ctpf_regs
`default_nettype wire

// ---- verif/ctpf_trig_model.sv ----
// External trigger source driving the GPIO pins
`timescale 1ns/100ps
`default_nettype none
module ctpf_trig_model
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Selected pin and its level
    input  wire logic [1:0] sel,
    input  wire logic       act,
    // Pin levels
    output var  logic [3:0] gpio_level
);
    logic act_r;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            act_r <= 1'b0;
        else
            act_r <= act;
    end
    // Other pins show the inverse so a wrong source shows
    always_comb
    begin
        gpio_level      = {4{~act_r}};
        gpio_level[sel] = act_r;
    end
endmodule // ctpf_trig_model
`default_nettype wire

// ---- verif/ctpf_regs_bench.sv ----
// Bench for the trigger, PWM and frame information registers
`timescale 1ns/100ps
`default_nettype none
module ctpf_regs_bench;
    logic        clk_sys, rstn, awv, wv, br, arv, rr, act;
    logic        awr, wr_rdy, bv, arr, rv, tp, te;
    logic [15:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0]  bresp, rresp, pwm;
    logic [3:0]  gpio, tmode;
    logic [11:0] tparam;
    int          mismatches, n_compared;

    ctpf_regs i_dut (.clk_sys(clk_sys), .rstn(rstn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .gpio_level(gpio), .pwm_out(pwm),
        .trig_pulse(tp), .trig_enabled(te), .trig_mode(tmode),
        .trig_param(tparam));
    ctpf_trig_model i_src (.clk_sys(clk_sys), .rstn(rstn), .sel(2'h2),
        .act(act), .gpio_level(gpio));

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    task print_verdict;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge clk_sys);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (n = 0; n < 50 && !bv; n++)
        begin
            @(posedge clk_sys);
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end
        br <= 1'b0;
        if (n == 50)
        begin
            mismatches++;
            print_verdict;
        end
        chk({30'h0, bresp}, {30'h0, e});
    endtask

    task rd(input logic [15:0] a, input logic [31:0] x, input logic [1:0] e);
        int n;
        @(posedge clk_sys);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (n = 0; n < 50 && !rv; n++)
        begin
            @(posedge clk_sys);
            if (arr) arv <= 1'b0;
        end
        rr <= 1'b0;
        if (n == 50)
        begin
            mismatches++;
            print_verdict;
        end
        chk(rdat, x);
        chk({30'h0, rresp}, {30'h0, e});
    endtask

    task t_reset;
        rd(16'h0830, 32'h0000_0801, 2'b00);
        rd(16'h1114, 32'h0000_0000, 2'b00);
        chk({31'h0, te}, 32'h0);
    endtask

    task t_trig;
        wr(16'h0830, 32'hfff0_f7c0, 2'b00);
        rd(16'h0830, 32'h0000_0841, 2'b00);
        wr(16'h0830, 32'habc0_32c0, 2'b00);
        rd(16'h0830, 32'habc0_02c1, 2'b00);
        wr(16'h0830, 32'h1230_02c2, 2'b00);
        wr(16'h0830, 32'h4560_02c2, 2'b00);
        rd(16'h0830, 32'h1230_02c3, 2'b00);
        chk({20'h0, tparam}, 32'h123);
        chk({28'h0, tmode}, 32'h0);
        chk({31'h0, te}, 32'h1);
    endtask

    task t_pulse;
        int n, c;
        c = 0;
        act <= 1'b1;
        for (n = 0; n < 8; n++)
        begin
            @(posedge clk_sys);
            c = c + int'(tp === 1'b1);
        end
        chk(c, 1);
        rd(16'h0830, 32'h1230_0ac3, 2'b00);
    endtask

    task t_pwm;
        int n, h, l;
        wr(16'h1110, 32'h0000_4000, 2'b00);
        wr(16'h1114, 32'h0003_0002, 2'b00);
        for (n = 0; n < 200 && pwm[0] !== 1'b0; n++) @(posedge clk_sys);
        for (n = 0; n < 200 && pwm[0] !== 1'b1; n++) @(posedge clk_sys);
        for (h = 0; h < 200 && pwm[0] === 1'b1; h++) @(posedge clk_sys);
        for (l = 0; l < 200 && pwm[0] === 1'b0; l++) @(posedge clk_sys);
        chk(h >= 56 && h <= 61, 1);
        chk(l >= 37 && l <= 41, 1);
        wr(16'h1124, 32'hdead_beef, 2'b00);
        rd(16'h1124, 32'hdead_beef, 2'b00);
        wr(16'h1120, 32'h8000_0000, 2'b00);
        @(posedge clk_sys);
        chk({31'h0, pwm[1]}, 32'h1);
        rd(16'h1120, 32'h8000_0001, 2'b00);
    endtask

    task t_frame;
        rd(16'h12f8, 32'h0000_ffc1, 2'b00);
        wr(16'h12f8, 32'hffff_ffff, 2'b00);
        rd(16'h12f8, 32'h0000_ffc1, 2'b00);
        wr(16'h0834, 32'h1, 2'b10);
        rd(16'h0834, 32'h0, 2'b10);
    endtask

    initial
    begin
        {rstn, awv, wv, br, arv, rr, act} = '0;
        {awa, ara, wd, mismatches, n_compared} = '0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset;
        t_trig;
        t_pulse;
        t_pwm;
        t_frame;
        print_verdict;
    end
endmodule // ctpf_regs_bench
`default_nettype wire
